// ---- spi_pkg.sv ----
// constants shared by the serial controller: register indices, field positions, reset values
// assumes a 40 MHz bus clock and a 32-bit AXI4-Lite register bus
package spi_pkg;
  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_CTRL1    = 3'h0;
  localparam logic [2:0] IDX_CTRL2    = 3'h1;
  localparam logic [2:0] IDX_BAUD     = 3'h2;
  localparam logic [2:0] IDX_STATUS   = 3'h3;
  localparam logic [2:0] IDX_DATA     = 3'h5;
  localparam logic [2:0] IDX_IRQ_MASK = 3'h6;
  localparam logic [2:0] IDX_IRQ_STAT = 3'h7;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int C1_EN      = 6;
  localparam int C1_MASTER  = 4;
  localparam int C1_CPOL    = 3;
  localparam int C1_CPHA    = 2;
  localparam int C2_TRANSFER_WIDTH_SEL    = 6;
  localparam int C2_MODE_FAULT_DETECT_EN  = 4;
  localparam int PRESEL_LSB = 4;
  localparam int SEL_LSB    = 0;
  localparam int ST_RXC     = 7;
  localparam int ST_TXE     = 5;
  localparam int ST_MODE_FAULT_FLAG    = 4;
  localparam int IRQ_RXC    = 0;
  localparam int IRQ_TXE    = 1;
  localparam int IRQ_MODE_FAULT_FLAG   = 2;
  // ----------------------------------------------------------------
  // reset values and answers
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'h00;
  localparam logic [2:0] MASK_RST  = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam logic [4:0] LAST_EDGE_8  = 5'h0f;
  localparam logic [4:0] LAST_EDGE_16 = 5'h1f;
endpackage

// ---- spi_ctrl.sv ----
// serial peripheral controller: baud divider, status flags, 8/16-bit frames, master and slave
// assumes AXI4-Lite master on aclk; serial pins are asynchronous and synchronised here
// Functional notes
// - the bit clock is the module clock divided by a divisor picked by six baud bits, 16 for 0x70, 2048 for 0x77.
// - the divisor is the preselect factor (value plus one) times the select factor (two to the value plus one).
// - the serial rate is the bus clock divided by the divisor, so 40 MHz over 16 gives 2.5 Mbit/s.
// - the status register reads at any time and writing it changes no flag.
// - status bit 7 goes high once received data is in the data register and is low before.
// - status bit 5 is high while the transmit data register is empty and low while it holds data.
// - as master with fault detection on, a low slave select input sets status bit 4.
// - the mode fault flag clears on a control register 1 write that follows a status read seeing it set.
// - with the width bit set, sixteen bits are shifted per frame.
// - with clock phase 1, slave select may stay low between frames and transfers go on.
// - a master with new data waiting at frame end starts it right after the half-period tail, with no idle time.
// - the receive flag rises one divider half period (set by the baud register) after the last clock edge, master or slave.
`timescale 1ns/1ps
module spi_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_n_i,
  output logic             ss_n_o,
  output logic             ss_n_oe,
  output logic             irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TAIL} phase_t;
  typedef struct packed {
    logic        awready, wready, arready, bvalid, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        aw_got, w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [7:0]  ctrl1, ctrl2, baud;
    logic [15:0] tx_buf, shifter, rx_sh, rx_data;
    logic        tx_empty, rx_done, mode_fault_flag, mode_fault_flag_seen;
    logic [2:0]  irq_st, irq_mask;
    logic        irq;
    phase_t      st;
    logic [10:0] half_cnt;
    logic [4:0]  edge_cnt;
    logic        sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe, ss_n, ss_oe;
    logic [2:0]  sy_sclk, sy_mosi, sy_miso, sy_ss;
  } regs_t;

  regs_t       r;
  regs_t       n;
  logic [10:0] half;
  logic        tick;
  logic        en;
  logic        mst;
  logic        cpha;
  logic        w16;
  logic        mode_fault_detect_en;
  logic        din;
  logic [4:0]  last;
  logic        wr_c1;

  // ----------------------------------------------------------------
  // divider and configuration
  // ----------------------------------------------------------------
  // half period = (presel+1) * 2^sel, so the full bit time is twice that
  assign half   = 11'(({8'h00, r.baud[spi_pkg::PRESEL_LSB +: 3]} + 11'h001) << r.baud[spi_pkg::SEL_LSB +: 3]);
  assign tick   = (r.half_cnt == half - 11'h001);
  assign en     = r.ctrl1[spi_pkg::C1_EN];
  assign mst    = r.ctrl1[spi_pkg::C1_MASTER];
  assign cpha   = r.ctrl1[spi_pkg::C1_CPHA];
  assign w16    = r.ctrl2[spi_pkg::C2_TRANSFER_WIDTH_SEL];
  assign mode_fault_detect_en = r.ctrl2[spi_pkg::C2_MODE_FAULT_DETECT_EN];
  assign din    = mst ? r.sy_miso[1] : r.sy_mosi[1];
  assign last   = w16 ? spi_pkg::LAST_EDGE_16 : spi_pkg::LAST_EDGE_8;

  // ----------------------------------------------------------------
  // frame helpers
  // ----------------------------------------------------------------
  function automatic regs_t load(regs_t s);
    s.shifter  = s.tx_empty ? s.shifter : s.tx_buf;
    s.tx_empty = 1'b1;
    s.st       = ST_RUN;
    s.half_cnt = 11'h000;
    s.edge_cnt = 5'h00;
    s.rx_sh    = 16'h0000;
    return s;
  endfunction

  function automatic regs_t shift_edge(regs_t s, logic ph, logic bit_in);
    if (s.edge_cnt[0] == ph) begin
      s.rx_sh = {s.rx_sh[14:0], bit_in};
    end else if (!(ph && s.edge_cnt == 5'h00)) begin
      s.shifter = {s.shifter[14:0], 1'b0};
    end
    s.edge_cnt = s.edge_cnt + 5'h01;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n       = r;
    wr_c1   = 1'b0;
    n.sy_sclk = {r.sy_sclk[1:0], sclk_i};
    n.sy_mosi = {r.sy_mosi[1:0], mosi_i};
    n.sy_miso = {r.sy_miso[1:0], miso_i};
    n.sy_ss   = {r.sy_ss[1:0], ss_n_i};
    // write channels are taken independently, the write happens once both are held
    if (r.awready && awvalid) begin
      n.aw_got  = 1'b1;
      n.awready = 1'b0;
      n.awaddr  = awaddr;
    end
    if (r.wready && wvalid) begin
      n.w_got  = 1'b1;
      n.wready = 1'b0;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = spi_pkg::RESP_OKAY;
      if (r.awaddr[7:5] != 3'h0) begin
        n.bresp = spi_pkg::RESP_SLV;
      end else if (r.awaddr[4:2] == spi_pkg::IDX_CTRL1) begin
        if (r.wstrb[0]) n.ctrl1 = r.wdata[7:0];
        wr_c1 = 1'b1;
      end else if (r.awaddr[4:2] == spi_pkg::IDX_CTRL2) begin
        if (r.wstrb[0]) n.ctrl2 = r.wdata[7:0];
      end else if (r.awaddr[4:2] == spi_pkg::IDX_BAUD) begin
        if (r.wstrb[0]) n.baud = r.wdata[7:0];
      end else if (r.awaddr[4:2] == spi_pkg::IDX_STATUS) begin
        n.bresp = spi_pkg::RESP_OKAY;
      end else if (r.awaddr[4:2] == spi_pkg::IDX_DATA) begin
        if (r.wstrb[0]) n.tx_buf[7:0] = r.wdata[7:0];
        if (r.wstrb[1]) n.tx_buf[15:8] = r.wdata[15:8];
        n.tx_empty = 1'b0;
      end else if (r.awaddr[4:2] == spi_pkg::IDX_IRQ_MASK) begin
        if (r.wstrb[0]) n.irq_mask = r.wdata[2:0];
      end else if (r.awaddr[4:2] == spi_pkg::IDX_IRQ_STAT) begin
        if (r.wstrb[0]) n.irq_st = r.irq_st & ~r.wdata[2:0];
      end else begin
        n.bresp = spi_pkg::RESP_SLV;
      end
    end
    if (r.bvalid && bready) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end
    if (r.arready && arvalid) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = spi_pkg::RESP_OKAY;
      n.rdata   = 32'h0000_0000;
      if (araddr[7:5] != 3'h0) begin
        n.rresp = spi_pkg::RESP_SLV;
      end else if (araddr[4:2] == spi_pkg::IDX_CTRL1) begin
        n.rdata[7:0] = r.ctrl1;
      end else if (araddr[4:2] == spi_pkg::IDX_CTRL2) begin
        n.rdata[7:0] = r.ctrl2;
      end else if (araddr[4:2] == spi_pkg::IDX_BAUD) begin
        n.rdata[7:0] = r.baud;
      end else if (araddr[4:2] == spi_pkg::IDX_STATUS) begin
        n.rdata[spi_pkg::ST_RXC]  = r.rx_done;
        n.rdata[spi_pkg::ST_TXE]  = r.tx_empty;
        n.rdata[spi_pkg::ST_MODE_FAULT_FLAG] = r.mode_fault_flag;
        if (r.mode_fault_flag) n.mode_fault_flag_seen = 1'b1;
      end else if (araddr[4:2] == spi_pkg::IDX_DATA) begin
        n.rdata[15:0] = r.rx_data;
        n.rx_done     = 1'b0;
      end else if (araddr[4:2] == spi_pkg::IDX_IRQ_MASK) begin
        n.rdata[2:0] = r.irq_mask;
      end else if (araddr[4:2] == spi_pkg::IDX_IRQ_STAT) begin
        n.rdata[2:0] = r.irq_st;
      end else begin
        n.rresp = spi_pkg::RESP_SLV;
      end
    end
    if (r.rvalid && rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
    if (wr_c1 && r.mode_fault_flag_seen) begin
      n.mode_fault_flag      = 1'b0;
      n.mode_fault_flag_seen = 1'b0;
    end
    // frame sequencing, after the bus so that a fault or a completion wins over a clear
    if (!en) begin
      n.st       = ST_IDLE;
      n.half_cnt = 11'h000;
    end else if (mst && mode_fault_detect_en && !r.sy_ss[1]) begin
      n.mode_fault_flag = 1'b1;
      n.st   = ST_IDLE;
    end else if (mst) begin
      case (r.st)
        ST_IDLE: begin
          if (!n.tx_empty) n = load(n);
        end
        ST_RUN: begin
          if (tick) begin
            n.half_cnt = 11'h000;
            n.sclk     = ~r.sclk;
            n          = shift_edge(n, cpha, din);
            if (r.edge_cnt == last) n.st = ST_TAIL;
          end else begin
            n.half_cnt = r.half_cnt + 11'h001;
          end
        end
        default: begin
          if (tick) begin
            n.rx_data = w16 ? n.rx_sh : {8'h00, n.rx_sh[7:0]};
            n.rx_done = 1'b1;
            n.st      = ST_IDLE;
            if (!n.tx_empty) n = load(n);
          end else begin
            n.half_cnt = r.half_cnt + 11'h001;
          end
        end
      endcase
    end else if (r.sy_ss[1]) begin
      n.st = ST_IDLE;
    end else begin
      case (r.st)
        ST_IDLE: begin
          n = load(n);
        end
        ST_RUN: begin
          if (r.sy_sclk[1] ^ r.sy_sclk[2]) begin
            n = shift_edge(n, cpha, din);
            if (r.edge_cnt == last) begin
              n.st       = ST_TAIL;
              n.half_cnt = 11'h000;
            end
          end
        end
        default: begin
          // edges that arrive here are not counted; the master's own tail covers this gap
          if (tick) begin
            n.rx_data = w16 ? n.rx_sh : {8'h00, n.rx_sh[7:0]};
            n.rx_done = 1'b1;
            n.st      = ST_IDLE;
          end else begin
            n.half_cnt = r.half_cnt + 11'h001;
          end
        end
      endcase
    end
    if (!mst || n.st == ST_IDLE) n.sclk = r.ctrl1[spi_pkg::C1_CPOL];
    n.ss_n    = !(mst && n.st != ST_IDLE);
    n.sclk_oe = en && mst;
    n.mosi_oe = en && mst;
    n.ss_oe   = en && mst && !mode_fault_detect_en;
    n.miso_oe = en && !mst && !r.sy_ss[1];
    n.mosi    = w16 ? n.shifter[15] : n.shifter[7];
    n.miso    = n.mosi;
    // sticky events, set after the write-one clear
    n.irq_st[spi_pkg::IRQ_RXC]  = n.irq_st[spi_pkg::IRQ_RXC] | (n.rx_done & ~r.rx_done);
    n.irq_st[spi_pkg::IRQ_TXE]  = n.irq_st[spi_pkg::IRQ_TXE] | (n.tx_empty & ~r.tx_empty);
    n.irq_st[spi_pkg::IRQ_MODE_FAULT_FLAG] = n.irq_st[spi_pkg::IRQ_MODE_FAULT_FLAG] | (n.mode_fault_flag & ~r.mode_fault_flag);
    n.irq = |(n.irq_st & n.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r          <= '0;
      r.awready  <= 1'b1;
      r.wready   <= 1'b1;
      r.arready  <= 1'b1;
      r.ctrl1    <= spi_pkg::CTRL1_RST;
      r.ctrl2    <= spi_pkg::CTRL2_RST;
      r.baud     <= spi_pkg::BAUD_RST;
      r.irq_mask <= spi_pkg::MASK_RST;
      r.tx_empty <= 1'b1;
      r.ss_n     <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign awready = r.awready;
  assign wready  = r.wready;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign arready = r.arready;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;
  assign sclk_o  = r.sclk;
  assign sclk_oe = r.sclk_oe;
  assign mosi_o  = r.mosi;
  assign mosi_oe = r.mosi_oe;
  assign miso_o  = r.miso;
  assign miso_oe = r.miso_oe;
  assign ss_n_o  = r.ss_n;
  assign ss_n_oe = r.ss_oe;
  assign irq     = r.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_BAUD_MAX: assert property (r.baud == 8'h77 |-> half == 11'h400) else $error("divisor 2048 wrong");
  AST_BAUD_16: assert property (r.baud == 8'h70 |-> half == 11'h008) else $error("divisor 16 wrong");
  AST_RXC_SRC: assert property ($rose(r.rx_done) |-> $past(r.st) == ST_TAIL) else $error("rx flag outside tail");
  AST_MODE_FAULT_FLAG_SET: assert property (en && mst && mode_fault_detect_en && !r.sy_ss[1] |=> r.mode_fault_flag) else $error("mode fault missed");
  AST_MODE_FAULT_FLAG_CLR: assert property ($fell(r.mode_fault_flag) |-> $past(wr_c1 && r.mode_fault_flag_seen)) else $error("mode_fault_flag cleared early");
  AST_B2B: assert property (en && mst && r.st == ST_TAIL && tick && !r.tx_empty && !(mode_fault_detect_en && !r.sy_ss[1])
                            |=> r.st == ST_RUN && !r.ss_n) else $error("no back-to-back start");
  AST_RXC_HALF: assert property ($rose(r.rx_done) |-> $past(r.half_cnt) == $past(half) - 11'h001)
    else $error("rx flag not half period after last edge");
  AST_TXE_LOAD: assert property ($rose(r.tx_empty) |-> $past(r.st) != ST_RUN && r.st == ST_RUN)
    else $error("empty flag set without a load");
endmodule

// ---- spi_peer.sv ----
// behavioural slave on the far side of the serial link: clock phase 1, clock idles low
// assumes the master drives the clock and slave select; miso is released while not selected
`timescale 1ns/1ps
module spi_peer (
  input  wire logic        sclk,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  input  wire logic        wide,
  input  wire logic [15:0] tx_word,
  output logic             miso,
  output logic [15:0]      rx_prev,
  output logic [15:0]      rx_last
);
  logic [15:0] sh_q = 16'h0000;
  logic [15:0] rx_q = 16'h0000;
  int          cnt_q = 0;
  initial begin
    miso = 1'b0;
    rx_prev = 16'h0000;
    rx_last = 16'h0000;
  end
  // ----------------------------------------------------------------
  // shifting
  // ----------------------------------------------------------------
  // a new word is taken at each frame start, also with select held low
  always @(posedge sclk) begin
    if (!ss_n) begin
      if (cnt_q == 0) sh_q = wide ? tx_word : {tx_word[7:0], 8'h00};
      miso = sh_q[15];
      sh_q = {sh_q[14:0], 1'b0};
    end
  end
  always @(negedge sclk) begin
    if (!ss_n) begin
      rx_q = {rx_q[14:0], mosi};
      cnt_q++;
      if (cnt_q == (wide ? 16 : 8)) begin
        rx_prev = rx_last;
        rx_last = wide ? rx_q : {8'h00, rx_q[7:0]};
        cnt_q = 0;
      end
    end
  end
  // released line keeps no value: flip it so a late sample is caught
  always @(posedge ss_n) begin
    miso = ~miso;
    cnt_q = 0;
  end
endmodule

// ---- tb_top.sv ----
// self-checking bench for spi_ctrl: AXI4-Lite register tasks, behavioural slave on the link
// assumes spi_pkg and spi_peer are compiled first
`timescale 1ns/1ps
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, irq;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic        sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, peer_miso;
  logic        sclk_w, mosi_w, miso_w, ss_n_w, ss_drv_n = 1'b1, wide = 1'b0;
  logic        sclk_drv = 1'b0, mosi_drv = 1'b0;
  logic        sclk_q = 1'b0, ss_q = 1'b1;
  logic [15:0] peer_tx = 16'h0000, rx_prev, rx_last;
  int          n_errors = 0, checks = 0, cyc = 0, last_rise = 0, per = 0, toggles = 0, ss_rises = 0;

  always #12.5 aclk = ~aclk;
  // the bench plays master on clock and mosi while the design is a slave; the clock idles low
  assign sclk_w = sclk_oe ? sclk_o : sclk_drv;
  assign mosi_w = mosi_oe ? mosi_o : mosi_drv;
  assign miso_w = miso_oe ? miso_o : peer_miso;
  assign ss_n_w = ss_n_oe ? ss_n_o : ss_drv_n;

  // serial clock period, edge count and select releases, sampled mid-cycle
  always @(negedge aclk) begin
    cyc <= cyc + 1;
    if (sclk_w && !sclk_q) begin
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (sclk_w !== sclk_q) toggles <= toggles + 1;
    if (ss_n_w && !ss_q) ss_rises <= ss_rises + 1;
    sclk_q <= sclk_w;
    ss_q <= ss_n_w;
  end

  spi_ctrl i_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .sclk_i(sclk_w),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n_w), .ss_n_o(ss_n_o),
    .ss_n_oe(ss_n_oe), .irq(irq));
  spi_peer i_peer (.sclk(sclk_w), .ss_n(ss_n_w), .mosi(mosi_w), .wide(wide), .tx_word(peer_tx),
    .miso(peer_miso), .rx_prev(rx_prev), .rx_last(rx_last));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic stall(input string what);
    n_errors++;
    $display("BAD wait %s expected done seen timeout", what);
    end_sim();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] ad(input logic [2:0] idx);
    return {3'h0, idx, 2'h0};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit done;
    done = 0;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        done = 1;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
    if (!done) stall("write");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    done = 0;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) stall("read");
  endtask
  task automatic rdc(input logic [2:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(ad(idx), d, r);
    chk("read data", exp, d);
  endtask
  task automatic wait_rx();
    logic [31:0] d;
    logic [1:0]  r;
    int n;
    for (n = 0; n < 10000; n++) begin
      rd(ad(spi_pkg::IDX_STATUS), d, r);
      if (d[spi_pkg::ST_RXC] === 1'b1) break;
    end
    if (n == 10000) stall("rx complete");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  ri [6];
    logic [7:0]  rv [6];
    logic [7:0]  bv [4];
    int          dv [4];
    logic [7:0]  xv [4];
    logic [7:0]  s_tx, s_rx;
    int          t0, s0;
    ri = '{spi_pkg::IDX_CTRL1, spi_pkg::IDX_CTRL2, spi_pkg::IDX_BAUD, spi_pkg::IDX_STATUS,
           spi_pkg::IDX_IRQ_MASK, spi_pkg::IDX_IRQ_STAT};
    rv = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
    bv = '{8'h00, 8'h70, 8'h75, 8'h77};
    dv = '{2, 16, 512, 2048};
    // at divisor 2 the two-flop miso sync lags one bit: the released line's level 1 leads the byte
    xv = '{8'h9e, 8'h3c, 8'h3c, 8'h3c};
    s_tx = 8'h5a;
    s_rx = 8'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(ri[i], {24'h0, rv[i]});
    wr(ad(spi_pkg::IDX_STATUS), 32'hff, spi_pkg::RESP_OKAY);
    rdc(spi_pkg::IDX_STATUS, 32'h20);
    wr(8'h10, 32'h1, spi_pkg::RESP_SLV);
    rd(8'h20, d, r);
    chk("rresp unmapped", {30'h0, spi_pkg::RESP_SLV}, {30'h0, r});
    $display("test registers done");
    // held data, enable, one 8-bit frame, then the interrupt path
    peer_tx <= 16'h003c;
    wr(ad(spi_pkg::IDX_BAUD), 32'h11, spi_pkg::RESP_OKAY);
    wr(ad(spi_pkg::IDX_DATA), 32'ha5, spi_pkg::RESP_OKAY);
    rdc(spi_pkg::IDX_STATUS, 32'h00);
    wr(ad(spi_pkg::IDX_IRQ_STAT), 32'h7, spi_pkg::RESP_OKAY);
    wr(ad(spi_pkg::IDX_IRQ_MASK), 32'h1, spi_pkg::RESP_OKAY);
    t0 = toggles;
    wr(ad(spi_pkg::IDX_CTRL1), 32'h54, spi_pkg::RESP_OKAY);
    wait_rx();
    rdc(spi_pkg::IDX_STATUS, 32'ha0);
    chk("edges 8-bit", 16, toggles - t0);
    chk("mosi word", 32'ha5, {16'h0, rx_last});
    chk("period", 8, per);
    rdc(spi_pkg::IDX_DATA, 32'h3c);
    rdc(spi_pkg::IDX_STATUS, 32'h20);
    @(negedge aclk);
    chk("irq on", 1, irq);
    rdc(spi_pkg::IDX_IRQ_STAT, 32'h3);
    wr(ad(spi_pkg::IDX_IRQ_MASK), 32'h0, spi_pkg::RESP_OKAY);
    @(negedge aclk);
    chk("irq masked", 0, irq);
    wr(ad(spi_pkg::IDX_IRQ_STAT), 32'h7, spi_pkg::RESP_OKAY);
    rdc(spi_pkg::IDX_IRQ_STAT, 32'h0);
    $display("test frame and irq done");
    for (int i = 0; i < 4; i++) begin
      wr(ad(spi_pkg::IDX_BAUD), {24'h0, bv[i]}, spi_pkg::RESP_OKAY);
      wr(ad(spi_pkg::IDX_DATA), 32'h0, spi_pkg::RESP_OKAY);
      wait_rx();
      rdc(spi_pkg::IDX_DATA, {24'h0, xv[i]});
      chk("divisor", dv[i], per);
    end
    $display("test divisors done");
    // 16-bit frames, second word loaded while the first is shifting
    wr(ad(spi_pkg::IDX_BAUD), 32'h11, spi_pkg::RESP_OKAY);
    wr(ad(spi_pkg::IDX_CTRL2), 32'h40, spi_pkg::RESP_OKAY);
    wide <= 1'b1;
    peer_tx <= 16'hc3a5;
    t0 = toggles;
    s0 = ss_rises;
    wr(ad(spi_pkg::IDX_DATA), 32'h1234, spi_pkg::RESP_OKAY);
    wr(ad(spi_pkg::IDX_DATA), 32'hbeef, spi_pkg::RESP_OKAY);
    wait_rx();
    rdc(spi_pkg::IDX_DATA, 32'hc3a5);
    wait_rx();
    rdc(spi_pkg::IDX_DATA, 32'hc3a5);
    repeat (8) @(posedge aclk);
    chk("first word", 32'h1234, {16'h0, rx_prev});
    chk("second word", 32'hbeef, {16'h0, rx_last});
    chk("edges 16-bit", 64, toggles - t0);
    chk("select releases", 1, ss_rises - s0);
    $display("test back to back done");
    // mode fault, then clearing only after a status read
    wide <= 1'b0;
    wr(ad(spi_pkg::IDX_CTRL2), 32'h10, spi_pkg::RESP_OKAY);
    wr(ad(spi_pkg::IDX_CTRL1), 32'h54, spi_pkg::RESP_OKAY);
    wr(ad(spi_pkg::IDX_IRQ_STAT), 32'h7, spi_pkg::RESP_OKAY);
    ss_drv_n <= 1'b0;
    repeat (6) @(posedge aclk);
    ss_drv_n <= 1'b1;
    rdc(spi_pkg::IDX_IRQ_STAT, 32'h4);
    wr(ad(spi_pkg::IDX_CTRL1), 32'h54, spi_pkg::RESP_OKAY);
    rdc(spi_pkg::IDX_STATUS, 32'h30);
    wr(ad(spi_pkg::IDX_CTRL1), 32'h54, spi_pkg::RESP_OKAY);
    rdc(spi_pkg::IDX_STATUS, 32'h20);
    $display("test mode fault done");
    // slave, clock phase 1: the bench clocks one byte at 8 cycles per half period
    wr(ad(spi_pkg::IDX_CTRL2), 32'h00, spi_pkg::RESP_OKAY);
    wr(ad(spi_pkg::IDX_CTRL1), 32'h44, spi_pkg::RESP_OKAY);
    wr(ad(spi_pkg::IDX_DATA), 32'h96, spi_pkg::RESP_OKAY);
    ss_drv_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      repeat (8) @(posedge aclk);
      if (i % 2 == 1) begin
        s_rx = {s_rx[6:0], miso_w};
      end else begin
        mosi_drv <= s_tx[7 - i / 2];
      end
      sclk_drv <= ~sclk_drv;
    end
    repeat (16) @(posedge aclk);
    ss_drv_n <= 1'b1;
    wait_rx();
    rdc(spi_pkg::IDX_DATA, {24'h0, s_tx});
    chk("slave miso", 32'h96, {24'h0, s_rx});
    $display("test slave done");
    end_sim();
  end
endmodule
